// >>> hw/smw_wait_ext.sv
// Operation
// - with float optimization off, float wait cycles follow a read before next access.
// - no float wait cycles added when read hold already covers the float period.
// - wait input used only in frozen or ready mode; mode off ignores it.
// - wait stretches access relative to the controlling strobe chosen by mode bits.
// - wait input sampled only during the controlling strobe's pulse phase.
// - frozen mode: synchronized low halts counters and holds all control outputs.
// - frozen mode: release resumes from exactly the stopped counter state.
// - ready mode: wait checked only in last cycle of the pulse phase.
// - ready mode: asserted at check suspends; after release, hold phase then completion.
// - ready mode: wait released early or asserted late leaves access length unchanged.
// - slow-clock indication selects fixed waveforms on every chip select.
// - slow read: strobe setup 1 pulse 1, cs setup 0 pulse 2, cycle 2.
// - slow write: strobe setup 1 pulse 1, cs setup 0 pulse 3, cycle 3.
// - transfer started in slow-clock mode finishes with the slow set.
// - slow-clock mode change inserts one reload wait cycle after current transfer.
// - float cycle count gives 0 to 15 float wait cycles.
// - float counted from strobe rise if strobe-controlled, else chip select rise.
module smw_wait_ext (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire logic                start_write,
  input  wire smw_pkg::smw_timing_t prog_rd,
  input  wire smw_pkg::smw_timing_t prog_wr,
  input  wire logic                rd_ctl_strobe,
  input  wire logic                wr_ctl_strobe,
  input  wire logic [1:0]          ext_wait_mode,
  input  wire logic [3:0]          float_cycles,
  input  wire logic                float_opt_en,
  input  wire logic                slow_clock_mode,
  input  wire logic                ext_wait_n,
  output logic                     busy,
  output logic                     done,
  output logic                     rd_strobe_n,
  output logic                     wr_strobe_n,
  output logic                     chip_sel_n
);

  // ==========================================
  // sequencer
  smw_pkg::smw_regs_t s_reg;
  smw_pkg::smw_regs_t s_next;

  // only the second synchronizer stage is read by logic
  wire logic wait_low = ~s_reg.wait_s2;

  logic [6:0] st_end;
  logic [6:0] cs_end;
  logic [6:0] ctl_setup;
  logic [6:0] ctl_end;
  logic [6:0] ctl_hold;
  logic       in_pulse;
  logic       last_pulse;
  logic       waiting;
  logic [4:0] float_need;

  always_comb begin
    st_end     = 7'(s_reg.tim.st_setup + s_reg.tim.st_pulse);
    cs_end     = 7'(s_reg.tim.cs_setup + s_reg.tim.cs_pulse);
    // controlling strobe per read/write mode
    ctl_setup  = s_reg.strobe_ctl ? s_reg.tim.st_setup : s_reg.tim.cs_setup;
    ctl_end    = s_reg.strobe_ctl ? st_end : cs_end;
    ctl_hold   = 7'(s_reg.tim.cycle - ctl_end);
    in_pulse   = (s_reg.cnt >= ctl_setup) && (s_reg.cnt < ctl_end);
    last_pulse = (s_reg.cnt == 7'(ctl_end - 7'h01));
    // mode off never looks at the wait input
    waiting    = (s_reg.state == smw_pkg::ST_ACCESS) && wait_low && !s_reg.slow_used &&
                 (((s_reg.wmode == smw_pkg::WAIT_FROZEN) && in_pulse) ||
                  ((s_reg.wmode == smw_pkg::WAIT_READY) && last_pulse));
    // float period minus what the hold phase already covers
    float_need = (7'(s_reg.float_cyc) > ctl_hold) ? 5'(7'(s_reg.float_cyc) - ctl_hold) : 5'h00;

    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      smw_pkg::ST_IDLE: begin
        if (s_reg.slow_s2 != s_reg.slow_used) begin
          s_next.state = smw_pkg::ST_RELOAD;
        end else if (start) begin
          s_next.state      = smw_pkg::ST_ACCESS;
          s_next.write      = start_write;
          s_next.strobe_ctl = start_write ? wr_ctl_strobe : rd_ctl_strobe;
          s_next.wmode      = ext_wait_mode;
          s_next.float_cyc  = float_opt_en ? 4'h0 : float_cycles;
          s_next.cnt        = 7'h00;
          if (s_reg.slow_used) begin
            s_next.tim = start_write ?
              {smw_pkg::SLOW_WR_SETUP, smw_pkg::SLOW_WR_PULSE, smw_pkg::SLOW_CS_WR_SETUP,
               smw_pkg::SLOW_CS_WR_PULSE, smw_pkg::SLOW_WR_CYCLE} :
              {smw_pkg::SLOW_RD_SETUP, smw_pkg::SLOW_RD_PULSE, smw_pkg::SLOW_CS_RD_SETUP,
               smw_pkg::SLOW_CS_RD_PULSE, smw_pkg::SLOW_RD_CYCLE};
          end else begin
            s_next.tim = start_write ? prog_wr : prog_rd;
          end
        end
      end
      smw_pkg::ST_RELOAD: begin
        // one cycle to reload configuration; slow set latched only here
        s_next.slow_used = s_reg.slow_s2;
        s_next.state     = smw_pkg::ST_IDLE;
      end
      smw_pkg::ST_ACCESS: begin
        if (waiting && s_reg.wmode == smw_pkg::WAIT_FROZEN) begin
          s_next = s_reg;
          s_next.done = 1'b0;
        end else if (waiting) begin
          s_next.state = smw_pkg::ST_SUSPEND;
        end else if (s_reg.cnt >= 7'(s_reg.tim.cycle - 7'h01)) begin
          if (!s_reg.write && float_need != 5'h00) begin
            s_next.state = smw_pkg::ST_FLOAT;
            s_next.fcnt  = 4'(float_need - 5'h01);
          end else begin
            s_next.state = smw_pkg::ST_IDLE;
            s_next.done  = 1'b1;
          end
        end else begin
          s_next.cnt = 7'(s_reg.cnt + 7'h01);
        end
      end
      smw_pkg::ST_SUSPEND: begin
        // outputs hold pulse level; hold phase runs after release
        if (!wait_low) begin
          s_next.state = smw_pkg::ST_ACCESS;
          s_next.cnt   = 7'(s_reg.cnt + 7'h01);
        end
      end
      smw_pkg::ST_FLOAT: begin
        if (s_reg.fcnt == 4'h0) begin
          s_next.state = smw_pkg::ST_IDLE;
          s_next.done  = 1'b1;
        end else begin
          s_next.fcnt = 4'(s_reg.fcnt - 4'h1);
        end
      end
      default: s_next.state = smw_pkg::ST_IDLE;
    endcase

    // strobe levels follow next counter; frozen keeps all outputs
    s_next.rd_strobe_n = 1'b1;
    s_next.wr_strobe_n = 1'b1;
    s_next.chip_sel_n  = 1'b1;
    if (s_next.state == smw_pkg::ST_ACCESS || s_next.state == smw_pkg::ST_SUSPEND) begin
      s_next.chip_sel_n = !((s_next.cnt >= s_next.tim.cs_setup) &&
                            (s_next.cnt < 7'(s_next.tim.cs_setup + s_next.tim.cs_pulse)));
      if (s_next.write) begin
        s_next.wr_strobe_n = !((s_next.cnt >= s_next.tim.st_setup) &&
                               (s_next.cnt < 7'(s_next.tim.st_setup + s_next.tim.st_pulse)));
      end else begin
        s_next.rd_strobe_n = !((s_next.cnt >= s_next.tim.st_setup) &&
                               (s_next.cnt < 7'(s_next.tim.st_setup + s_next.tim.st_pulse)));
      end
    end

    // synchronizer keeps running even while an access is frozen
    s_next.wait_s1 = ext_wait_n;
    s_next.wait_s2 = s_reg.wait_s1;
    s_next.slow_s1 = slow_clock_mode;
    s_next.slow_s2 = s_reg.slow_s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg             <= '0;
      s_reg.wait_s1     <= 1'b1;
      s_reg.wait_s2     <= 1'b1;
      s_reg.state       <= smw_pkg::ST_IDLE;
      s_reg.rd_strobe_n <= 1'b1;
      s_reg.wr_strobe_n <= 1'b1;
      s_reg.chip_sel_n  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy        = (s_reg.state != smw_pkg::ST_IDLE);
  assign done        = s_reg.done;
  assign rd_strobe_n = s_reg.rd_strobe_n;
  assign wr_strobe_n = s_reg.wr_strobe_n;
  assign chip_sel_n  = s_reg.chip_sel_n;

  // ==========================================
  // checks
  property p_frozen_hold;
    @(posedge clk) disable iff (rst)
      (waiting && s_reg.wmode == smw_pkg::WAIT_FROZEN) |=>
        ($stable(s_reg.cnt) && $stable(chip_sel_n) && $stable(rd_strobe_n) && $stable(wr_strobe_n));
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("frozen access moved");

  property p_frozen_resume;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_ACCESS && $past(waiting) && !waiting && s_reg.wmode == smw_pkg::WAIT_FROZEN
       && s_reg.cnt < 7'(s_reg.tim.cycle - 7'h01)) |=> (s_reg.cnt == 7'($past(s_reg.cnt) + 7'h01));
  endproperty
  a_frozen_resume: assert property (p_frozen_resume) else $error("frozen resume lost count");

  property p_off_ignores;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_ACCESS && s_reg.wmode == smw_pkg::WAIT_OFF
       && s_reg.cnt < 7'(s_reg.tim.cycle - 7'h01)) |=> (s_reg.cnt == 7'($past(s_reg.cnt) + 7'h01));
  endproperty
  a_off_ignores: assert property (p_off_ignores) else $error("wait honoured with mode off");

  property p_ready_suspend;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_ACCESS && s_reg.wmode == smw_pkg::WAIT_READY && !s_reg.slow_used
       && last_pulse && wait_low) |=> (s_reg.state == smw_pkg::ST_SUSPEND);
  endproperty
  a_ready_suspend: assert property (p_ready_suspend) else $error("ready check missed");

  property p_ready_only_last;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_ACCESS && !last_pulse) |=> (s_reg.state != smw_pkg::ST_SUSPEND);
  endproperty
  a_ready_only_last: assert property (p_ready_only_last) else $error("suspend outside last pulse");

  property p_resume_ready;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_SUSPEND && !wait_low) |=> (s_reg.state == smw_pkg::ST_ACCESS);
  endproperty
  a_resume_ready: assert property (p_resume_ready) else $error("suspend not released");

  sequence s_reload_step;
    (s_reg.state == smw_pkg::ST_RELOAD) ##1
      (s_reg.state == smw_pkg::ST_IDLE && s_reg.slow_used == $past(s_reg.slow_s2));
  endsequence

  property p_reload;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_IDLE && s_reg.slow_s2 != s_reg.slow_used) |=> s_reload_step;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload cycle on slow change");

  property p_slow_set;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_IDLE && start && s_reg.slow_used && s_reg.slow_s2 && !start_write) |=>
        (s_reg.tim.cycle == smw_pkg::SLOW_RD_CYCLE && s_reg.tim.cs_pulse == smw_pkg::SLOW_CS_RD_PULSE);
  endproperty
  a_slow_set: assert property (p_slow_set) else $error("slow read set not applied");

  property p_slow_keep;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_ACCESS) |=> $stable(s_reg.slow_used);
  endproperty
  a_slow_keep: assert property (p_slow_keep) else $error("slow set changed mid transfer");

  property p_float;
    @(posedge clk) disable iff (rst)
      (s_reg.state == smw_pkg::ST_ACCESS && s_next.state == smw_pkg::ST_FLOAT) |->
        (!s_reg.write && 7'(s_reg.float_cyc) > ctl_hold);
  endproperty
  a_float: assert property (p_float) else $error("float wait without need");

endmodule

// >>> hw/smw_pkg.sv
package smw_pkg;

  // ==========================================
  // wait modes
  localparam logic [1:0] WAIT_OFF    = 2'h0;
  localparam logic [1:0] WAIT_FROZEN = 2'h2;
  localparam logic [1:0] WAIT_READY  = 2'h3;

  // ==========================================
  // widths
  localparam int unsigned CW = 7;
  localparam int unsigned FW = 4;

  // ==========================================
  // slow-clock waveform set, in cycles
  localparam logic [6:0] SLOW_RD_SETUP    = 7'h01;
  localparam logic [6:0] SLOW_RD_PULSE    = 7'h01;
  localparam logic [6:0] SLOW_CS_RD_SETUP = 7'h00;
  localparam logic [6:0] SLOW_CS_RD_PULSE = 7'h02;
  localparam logic [6:0] SLOW_RD_CYCLE    = 7'h02;
  localparam logic [6:0] SLOW_WR_SETUP    = 7'h01;
  localparam logic [6:0] SLOW_WR_PULSE    = 7'h01;
  localparam logic [6:0] SLOW_CS_WR_SETUP = 7'h00;
  localparam logic [6:0] SLOW_CS_WR_PULSE = 7'h03;
  localparam logic [6:0] SLOW_WR_CYCLE    = 7'h03;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RELOAD,
    ST_ACCESS,
    ST_SUSPEND,
    ST_FLOAT
  } smw_state_t;

  // ==========================================
  // timing set for one access (strobe, chip select, total)
  typedef struct packed {
    logic [6:0] st_setup;
    logic [6:0] st_pulse;
    logic [6:0] cs_setup;
    logic [6:0] cs_pulse;
    logic [6:0] cycle;
  } smw_timing_t;

  typedef struct packed {
    smw_state_t  state;
    smw_timing_t tim;
    logic        write;
    logic        strobe_ctl;
    logic [1:0]  wmode;
    logic [3:0]  float_cyc;
    logic [6:0]  cnt;
    logic [3:0]  fcnt;
    logic        slow_used;
    logic        rd_strobe_n;
    logic        wr_strobe_n;
    logic        chip_sel_n;
    logic        done;
    logic        wait_s1;
    logic        wait_s2;
    logic        slow_s1;
    logic        slow_s2;
  } smw_regs_t;

endpackage

// >>> sim/smw_mem_model.sv
// ==========================================
// far-side device: pulls the wait line low a set time after the controlling strobe falls
module smw_mem_model (
  input  wire logic       clk,
  input  wire logic       rd_strobe_n,
  input  wire logic       wr_strobe_n,
  input  wire logic       chip_sel_n,
  input  wire logic       watch_cs,
  input  wire logic [7:0] wait_delay,
  input  wire logic [7:0] wait_len,
  output logic            ext_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctl_n;
  logic ctl_q;
  int   cnt;
  // only strobe-controlled or cs-controlled access, never page or slow waveforms
  assign ctl_n = watch_cs ? chip_sel_n : (rd_strobe_n & wr_strobe_n);
  initial begin
    ext_wait_n = 1'b1;
    ctl_q      = 1'b1;
    cnt        = -1;
  end
  always @(posedge clk) begin
    ctl_q <= ctl_n;
    if (ctl_q && !ctl_n && wait_len != 8'h00) begin
      cnt <= 0;
    end else if (cnt >= 0) begin
      cnt <= (cnt < int'(wait_delay) + int'(wait_len)) ? cnt + 1 : -1;
    end
    // pulled up when released; signed compare keeps the idle count of -1 quiet
    ext_wait_n <= !(cnt >= int'(wait_delay) && cnt < int'(wait_delay) + int'(wait_len));
  end
endmodule

// >>> sim/test_smw_wait_ext.sv
module test_smw_wait_ext;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, rst, start, start_write, rd_ctl_strobe, wr_ctl_strobe;
  logic                 float_opt_en, slow_clock_mode, ext_wait_n, watch_cs;
  logic                 busy, done, rd_strobe_n, wr_strobe_n, chip_sel_n;
  logic [1:0]           ext_wait_mode;
  logic [3:0]           float_cycles;
  logic [7:0]           wait_delay, wait_len;
  smw_pkg::smw_timing_t prog_rd, prog_wr;
  int                   failures, tests_run, cycles;
  int                   cs_low, rd_low, wr_low;

  smw_wait_ext uut (.clk(clk), .rst(rst), .start(start), .start_write(start_write), .prog_rd(prog_rd),
    .prog_wr(prog_wr), .rd_ctl_strobe(rd_ctl_strobe), .wr_ctl_strobe(wr_ctl_strobe),
    .ext_wait_mode(ext_wait_mode), .float_cycles(float_cycles), .float_opt_en(float_opt_en),
    .slow_clock_mode(slow_clock_mode), .ext_wait_n(ext_wait_n), .busy(busy), .done(done),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n), .chip_sel_n(chip_sel_n));
  smw_mem_model dev (.clk(clk), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .chip_sel_n(chip_sel_n), .watch_cs(watch_cs), .wait_delay(wait_delay), .wait_len(wait_len),
    .ext_wait_n(ext_wait_n));

  always #5 clk = ~clk;

  // ==========================================
  // checking and closing
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // one access; n is cycles from the taking edge to the done pulse
  // returns on the negedge that shows done; state is idle there, so the next start may follow at once
  task automatic access(input logic wr, output int n);
    start = 1'b1;
    start_write = wr;
    cs_low = 0;
    rd_low = 0;
    wr_low = 0;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      cs_low += int'(chip_sel_n === 1'b0);
      rd_low += int'(rd_strobe_n === 1'b0);
      wr_low += int'(wr_strobe_n === 1'b0);
      @(negedge clk);
      n++;
    end
  endtask
  // busy cycles seen while idle, i.e. reload cycles
  task automatic idle_busy(output int b);
    b = 0;
    repeat (6) begin
      @(negedge clk);
      if (busy === 1'b1) b++;
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_float();
    int n;
    prog_rd = '{7'h01, 7'h02, 7'h00, 7'h04, 7'h04};
    prog_wr = prog_rd;
    float_opt_en = 1'b0;
    float_cycles = 4'h5;
    access(1'b0, n); check("float_strobe_rd", n, 8);
    check("float_rd_cs_low", cs_low, 4);
    check("float_rd_strobe_low", rd_low, 2);
    float_cycles = 4'h1;
    access(1'b0, n); check("float_in_hold", n, 4);
    float_cycles = 4'hf;
    access(1'b0, n); check("float_max", n, 18);
    rd_ctl_strobe = 1'b0;
    float_cycles = 4'h3;
    access(1'b0, n); check("float_cs_rd", n, 7);
    access(1'b1, n); check("float_write", n, 4);
    float_opt_en = 1'b1;
    access(1'b0, n); check("float_opt_on", n, 4);
    rd_ctl_strobe = 1'b1;
  endtask

  task automatic t_wait();
    int n;
    // wr, cs, mode, delay, len, lo, hi
    int tbl[8][7] = '{'{0, 0, 0, 1, 5, 10, 10}, '{0, 0, 2, 1, 3, 13, 13}, '{0, 0, 2, 10, 3, 10, 10},
      '{0, 0, 3, 1, 12, 20, 20}, '{0, 0, 3, 1, 2, 10, 10}, '{0, 0, 3, 10, 3, 10, 10},
      '{1, 1, 2, 1, 3, 13, 13}, '{1, 1, 3, 1, 12, 19, 19}};
    // pulses 8 and 9 cover the wait latency plus sync 2 plus 1; one hold cycle on strobe and cs alike
    prog_rd = '{7'h01, 7'h08, 7'h00, 7'h09, 7'h0a};
    prog_wr = prog_rd;
    float_opt_en = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr_ctl_strobe = !tbl[i][1][0];
      watch_cs = tbl[i][1][0];
      ext_wait_mode = tbl[i][2][1:0];
      wait_delay = tbl[i][3][7:0];
      wait_len = tbl[i][4][7:0];
      access(tbl[i][0][0], n);
      check("wait_len_ok", (n >= tbl[i][5] && n <= tbl[i][6]), 1);
      // let a late wait pulse die out so it cannot reach the next row
      repeat (16) @(negedge clk);
    end
    ext_wait_mode = smw_pkg::WAIT_OFF;
    wait_len = 8'h00;
    watch_cs = 1'b0;
  endtask

  task automatic t_slow();
    int n;
    int b;
    slow_clock_mode = 1'b1;
    idle_busy(b); check("reload_enter", b, 1);
    access(1'b0, n); check("slow_rd", n, 2);
    check("slow_rd_cs_low", cs_low, 2);
    check("slow_rd_strobe_low", rd_low, 1);
    access(1'b1, n); check("slow_wr", n, 3);
    check("slow_wr_cs_low", cs_low, 3);
    check("slow_wr_strobe_low", wr_low, 1);
    // indication drops as the read is taken: slow set still applies
    slow_clock_mode = 1'b0;
    access(1'b0, n); check("slow_exit_rd", n, 2);
    idle_busy(b); check("reload_exit", b, 1);
    access(1'b0, n); check("fast_rd", n, 10);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    start_write = 1'b0;
    rd_ctl_strobe = 1'b1;
    wr_ctl_strobe = 1'b1;
    float_opt_en = 1'b1;
    slow_clock_mode = 1'b0;
    watch_cs = 1'b0;
    ext_wait_mode = smw_pkg::WAIT_OFF;
    float_cycles = 4'h0;
    wait_delay = 8'h00;
    wait_len = 8'h00;
    prog_rd = '{7'h01, 7'h02, 7'h00, 7'h04, 7'h04};
    prog_wr = prog_rd;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    check("rst_rd_strobe", rd_strobe_n, 1);
    check("rst_wr_strobe", wr_strobe_n, 1);
    check("rst_busy", busy, 0);
    check("rst_chip_sel", chip_sel_n, 1);
    check("rst_done", done, 0);
    t_float();
    t_wait();
    t_slow();
    summarize();
  end
endmodule
